// File: design/rtcot_core.sv
// rtcot_core: oscillator control and bcd time/calendar counters.
// assumes a serial front end that turns bus traffic into req_in strobes.
//
// Behaviour
// (R1) software sets the start bit; crystal oscillator stays off while clear
// (R2) software sets external clock enable before a 32.768 kHz input is used
// (R3) running flag sets itself after 32 oscillator cycles are seen
// (R4) running flag clears after no cycles for longer than the timeout
// (R5) separate seconds to year counters, all clocked by the oscillator
// (R6) short months handled; leap years correct for 2001 to 2399
// (R7) 12 or 24 hour format chosen by the format bit in hours
// (R8) weekday counts 1 to 7, advances at midnight, no fixed day names
// (R9) all time and date values held as bcd
// (R10) buffer refreshed when a read starts at addresses 0x00 to 0x1f
// (R11) buffer refreshed again when the burst address wraps 0x1f to 0x00
// (R12) host should read all time registers in one burst
// (R13) host writes only valid values; invalid values give undefined result
// (R14) host stops the clock, waits for flag clear, writes, restarts
// (R15) midnight rollover in either format carries to date and weekday
// (R16) weekday wraps 7 to 1 with no carry
// (R17) december 31 rolls to january 01 and carries to year
// (R18) year wraps 99 to 00 with no carry
// (R19) month lengths 31 or 30; february 29 in leap years, else 28
// (R20) start bit 7 of seconds, flag bit 5 of weekday, ext bit 3 control
// (R21) 12-hour: bit 5 of hours is pm indicator; tens digit 0 or 1
// (R22) leap year bit in month register is read-only, 1 in leap years
// (R23) seconds advance every 32768 source cycles while enabled and running
`timescale 1ns/1ps
module rtcot_core #(
	parameter int unsigned OSF_CYCLES = rtcot_pkg::OSF_CYCLES_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic osc_input_pin_in,
	input wire rtcot_pkg::rtcot_req_t req_in,
	output logic [7:0] rdata_out,
	output logic osc_running_flag_out
);
	rtcot_pkg::rtcot_state_t s;
	rtcot_pkg::rtcot_state_t next_s;
	logic osc_start_bit;
	logic ext_clock_enable;
	logic src_enable;
	logic osc_edge;
	logic osc_running_flag;
	logic active;
	logic tick;
	logic c_min;
	logic c_hr;
	logic c_day;
	logic c_mth;
	logic c_yr;
	logic leap_year_flag;
	logic refresh;
	logic [7:0] t;
	logic [7:0] h12;
	logic [rtcot_pkg::SNAP_WORDS-1:0][7:0] live;
	logic [7:0] live_pick;

	// ----------------------------------------
	// bcd helpers
	// ----------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	// year 00 is read as 2100, which is not a leap year
	function automatic logic is_leap(input logic [7:0] y);
		if (y == 8'h00)
			is_leap = 1'b0;
		else if (!y[4])
			is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
				(y[3:0] == 4'h8);
		else
			is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
	endfunction : is_leap

	function automatic logic [5:0] month_last(input logic [4:0] m,
		input logic lp);
		case (m)
			5'h02: month_last = lp ? 6'h29 : 6'h28;
			5'h04, 5'h06, 5'h09, 5'h11: month_last = 6'h30;
			default: month_last = 6'h31;
		endcase
	endfunction : month_last

	// ----------------------------------------
	// oscillator
	// ----------------------------------------
	assign osc_start_bit = s.st;
	assign ext_clock_enable = s.ctrl[rtcot_pkg::EXT_BIT];
	// either source bit powers the pin path; both clear means no edges
	assign src_enable = osc_start_bit | ext_clock_enable; // R1 R2

	rtcot_osc_mon #(
		.OSF_CYCLES(OSF_CYCLES)
	) u_mon (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.osc_input_pin_in(osc_input_pin_in),
		.enable_in(src_enable),
		.edge_out(osc_edge),
		.running_out(osc_running_flag)
	);

	assign active = src_enable & osc_running_flag; // R23
	assign tick = osc_edge & active & (s.pre == rtcot_pkg::PRESCALE_LAST);
	assign leap_year_flag = is_leap(s.year); // R6

	// ----------------------------------------
	// counters, writes and read pointer
	// ----------------------------------------
	always_comb begin
		next_s = s;
		c_min = 1'b0;
		c_hr = 1'b0;
		c_day = 1'b0;
		c_mth = 1'b0;
		c_yr = 1'b0;
		t = 8'h00;
		h12 = {3'b000, s.hour[4:0]};
		refresh = 1'b0;
		if (osc_edge && active)
			next_s.pre = s.pre + 15'h0001; // R23
		if (tick) begin
			if (s.sec == 7'h59) begin
				next_s.sec = 7'h00;
				c_min = 1'b1;
			end else begin
				t = bcd_inc({1'b0, s.sec}); // R9
				next_s.sec = t[6:0]; // R5
			end
		end
		if (c_min) begin
			if (s.min == 7'h59) begin
				next_s.min = 7'h00;
				c_hr = 1'b1;
			end else begin
				t = bcd_inc({1'b0, s.min});
				next_s.min = t[6:0];
			end
		end
		if (c_hr) begin
			if (!s.fmt12) begin
				if (s.hour == 6'h23) begin
					next_s.hour = 6'h00; // R15
					c_day = 1'b1;
				end else begin
					t = bcd_inc({2'b00, s.hour});
					next_s.hour = t[5:0]; // R7
				end
			end else if (h12 == 8'h11) begin
				next_s.hour = {~s.hour[5], 5'h12}; // R21
				c_day = s.hour[5]; // R15
			end else if (h12 == 8'h12) begin
				next_s.hour = {s.hour[5], 5'h01}; // R7
			end else begin
				t = bcd_inc(h12);
				next_s.hour = {s.hour[5], t[4:0]};
			end
		end
		if (c_day) begin
			if (s.wk == 3'h7)
				next_s.wk = 3'h1; // R16
			else
				next_s.wk = s.wk + 3'h1; // R8
			if (s.date == month_last(s.mth, leap_year_flag)) begin
				next_s.date = 6'h01; // R19
				c_mth = 1'b1;
			end else begin
				t = bcd_inc({2'b00, s.date});
				next_s.date = t[5:0];
			end
		end
		if (c_mth) begin
			if (s.mth == 5'h12) begin
				next_s.mth = 5'h01; // R17
				c_yr = 1'b1;
			end else begin
				t = bcd_inc({3'b000, s.mth});
				next_s.mth = t[4:0];
			end
		end
		if (c_yr)
			next_s.year = (s.year == 8'h99) ? 8'h00 : bcd_inc(s.year); // R18
		// a write replaces only its own register; a carry elsewhere stands
		if (req_in.wr) begin
			if (req_in.addr == rtcot_pkg::ADDR_SEC) begin
				next_s.st = req_in.wdata[rtcot_pkg::START_BIT]; // R20
				next_s.sec = req_in.wdata[6:0];
			end else if (req_in.addr == rtcot_pkg::ADDR_MIN) begin
				next_s.min = req_in.wdata[6:0];
			end else if (req_in.addr == rtcot_pkg::ADDR_HOUR) begin
				next_s.fmt12 = req_in.wdata[rtcot_pkg::FMT_BIT]; // R7
				next_s.hour = req_in.wdata[5:0];
			end else if (req_in.addr == rtcot_pkg::ADDR_WKDAY) begin
				next_s.wk = req_in.wdata[2:0];
			end else if (req_in.addr == rtcot_pkg::ADDR_DATE) begin
				next_s.date = req_in.wdata[5:0];
			end else if (req_in.addr == rtcot_pkg::ADDR_MTH) begin
				next_s.mth = req_in.wdata[4:0]; // R22
			end else if (req_in.addr == rtcot_pkg::ADDR_YEAR) begin
				next_s.year = req_in.wdata;
			end else if (req_in.addr == rtcot_pkg::ADDR_CTRL) begin
				next_s.ctrl = req_in.wdata; // R20
			end
		end
		if (req_in.rd_start) begin
			next_s.ptr = req_in.addr[4:0];
			refresh = (req_in.addr <= rtcot_pkg::ADDR_LAST); // R10
		end else if (req_in.rd_next) begin
			next_s.ptr = s.ptr + 5'h01;
			refresh = (s.ptr == rtcot_pkg::ADDR_LAST[4:0]); // R11
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in)
			s <= rtcot_pkg::STATE_RESET;
		else
			s <= next_s;
	end

	// ----------------------------------------
	// read side
	// ----------------------------------------
	// the flag sits in the weekday byte and the leap bit in the month byte
	assign live[0] = {s.st, s.sec};
	assign live[1] = {1'b0, s.min};
	assign live[2] = {1'b0, s.fmt12, s.hour};
	assign live[3] = {2'b00, osc_running_flag, 2'b00, s.wk}; // R20
	assign live[4] = {2'b00, s.date};
	assign live[5] = {2'b00, leap_year_flag, s.mth}; // R22
	assign live[6] = s.year;
	assign live[7] = s.ctrl;

	rtcot_snap u_snap (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.live_in(live),
		.refresh_in(refresh),
		.idx_in(next_s.ptr),
		.rdata_out(rdata_out)
	);

	assign osc_running_flag_out = osc_running_flag;
	assign live_pick = live[req_in.addr[2:0]];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_tick_gate;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		tick |-> (src_enable && osc_running_flag && osc_edge);
	endproperty
	a_tick_gate: assert property (p_tick_gate) // R23
		else $error("second advanced while source not running");

	property p_sec_wrap;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(tick && s.sec == 7'h59 && !req_in.wr) |=>
			(s.sec == 7'h00 && s.min != $past(s.min));
	endproperty
	a_sec_wrap: assert property (p_sec_wrap) // R5
		else $error("seconds did not wrap into minutes");

	property p_midnight;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(tick && !s.fmt12 && s.hour == 6'h23 && s.min == 7'h59 &&
			s.sec == 7'h59 && !req_in.wr) |=>
			(s.hour == 6'h00 && s.wk != $past(s.wk));
	endproperty
	a_midnight: assert property (p_midnight) // R15
		else $error("midnight did not carry into weekday");

	property p_wk_wrap;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(c_day && s.wk == 3'h7 && !req_in.wr) |=> (s.wk == 3'h1);
	endproperty
	a_wk_wrap: assert property (p_wk_wrap) // R16
		else $error("weekday did not wrap to 1");

	property p_feb;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(c_day && s.mth == 5'h02 && s.date == 6'h28 && !leap_year_flag &&
			!req_in.wr) |=> (s.date == 6'h01 && s.mth == 5'h03);
	endproperty
	a_feb: assert property (p_feb) // R19
		else $error("february end in a common year wrong");

	property p_year_wrap;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(c_yr && s.year == 8'h99 && !req_in.wr) |=> (s.year == 8'h00);
	endproperty
	a_year_wrap: assert property (p_year_wrap) // R18
		else $error("year did not wrap to 00");

	property p_hour12;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(c_hr && s.fmt12 && s.hour == 6'h31 && !req_in.wr) |=>
			(s.hour == 6'h12 && c_day == 1'b0);
	endproperty
	a_hour12: assert property (p_hour12) // R21
		else $error("11 pm did not roll to 12 am");

	property p_refresh;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(req_in.rd_start && req_in.addr < 8'h08 && !req_in.wr) |=>
			(rdata_out == $past(live_pick));
	endproperty
	a_refresh: assert property (p_refresh) // R10
		else $error("read start did not return fresh time byte");
endmodule : rtcot_core

// File: design/rtcot_pkg.sv
// rtcot_pkg: shared constants and carriers of the rtc timekeeping core.
// assumes a 40 MHz core clock and a register port fed by a serial front end.
package rtcot_pkg;

// ----------------------------------------
// register offsets and bit positions
// ----------------------------------------
localparam logic [7:0] ADDR_SEC = 8'h00;
localparam logic [7:0] ADDR_MIN = 8'h01;
localparam logic [7:0] ADDR_HOUR = 8'h02;
localparam logic [7:0] ADDR_WKDAY = 8'h03;
localparam logic [7:0] ADDR_DATE = 8'h04;
localparam logic [7:0] ADDR_MTH = 8'h05;
localparam logic [7:0] ADDR_YEAR = 8'h06;
localparam logic [7:0] ADDR_CTRL = 8'h07;
localparam logic [7:0] ADDR_LAST = 8'h1f;
localparam int START_BIT = 7;
localparam int RUN_BIT = 5;
localparam int EXT_BIT = 3;
localparam int FMT_BIT = 6;
localparam int SNAP_WORDS = 8;

// ----------------------------------------
// reset values and counts
// ----------------------------------------
localparam logic [2:0] WK_RESET = 3'h1;
localparam logic [5:0] DATE_RESET = 6'h01;
localparam logic [4:0] MTH_RESET = 5'h01;
localparam logic [7:0] YEAR_RESET = 8'h01;
localparam logic [5:0] RUN_EDGES = 6'h20;
localparam logic [14:0] PRESCALE_LAST = 15'h7fff;
localparam int CLK_MHZ = 40;
// failure timeout is not fixed by the part; plain default
localparam int OSF_TIMEOUT_US = 1000;
localparam int OSF_CYCLES_DEF = OSF_TIMEOUT_US * CLK_MHZ;
localparam int IDLE_W = 24;

// ----------------------------------------
// carriers
// ----------------------------------------
typedef struct packed {
	logic [7:0] addr;
	logic wr;
	logic [7:0] wdata;
	logic rd_start;
	logic rd_next;
} rtcot_req_t;

typedef struct packed {
	logic st;
	logic [6:0] sec;
	logic [6:0] min;
	logic fmt12;
	logic [5:0] hour;
	logic [2:0] wk;
	logic [5:0] date;
	logic [4:0] mth;
	logic [7:0] year;
	logic [7:0] ctrl;
	logic [14:0] pre;
	logic [4:0] ptr;
} rtcot_state_t;

localparam rtcot_state_t STATE_RESET = '{wk: WK_RESET, date: DATE_RESET,
	mth: MTH_RESET, year: YEAR_RESET, default: '0};

typedef struct packed {
	logic s1;
	logic s2;
	logic prev;
	logic [5:0] edges;
	logic [IDLE_W-1:0] idle;
	logic run;
} rtcot_mon_t;

endpackage : rtcot_pkg

// File: design/rtcot_osc_mon.sv
// rtcot_osc_mon: oscillator edge detector and running/failure flag.
// assumes the oscillator pin is asynchronous to the core clock.
`timescale 1ns/1ps
module rtcot_osc_mon #(
	parameter int unsigned OSF_CYCLES = rtcot_pkg::OSF_CYCLES_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic osc_input_pin_in,
	input wire logic enable_in,
	output logic edge_out,
	output logic running_out
);
	localparam logic [rtcot_pkg::IDLE_W-1:0] LIM =
		OSF_CYCLES[rtcot_pkg::IDLE_W-1:0];
	rtcot_pkg::rtcot_mon_t s;
	rtcot_pkg::rtcot_mon_t next_s;
	logic edge_ok;

	// ----------------------------------------
	// edge counting and timeout
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.s1 = osc_input_pin_in;
		next_s.s2 = s.s1;
		next_s.prev = s.s2;
		// a stopped source simply shows no edges, so disable ends in timeout
		edge_ok = s.s2 & ~s.prev & enable_in;
		if (edge_ok) begin
			next_s.idle = '0;
			if (s.edges != rtcot_pkg::RUN_EDGES)
				next_s.edges = s.edges + 6'h01; // R3
		end else if (s.idle != LIM) begin
			next_s.idle = s.idle + 1'b1;
		end else begin
			next_s.edges = '0;
			next_s.run = 1'b0; // R4
		end
		if (next_s.edges == rtcot_pkg::RUN_EDGES)
			next_s.run = 1'b1; // R3
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign edge_out = edge_ok;
	assign running_out = s.run;

	property p_run_set;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!s.run && s.edges == 6'h1f && edge_ok) |=> running_out;
	endproperty
	a_run_set: assert property (p_run_set) // R3
		else $error("running flag not set after 32 edges");

	property p_run_clr;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(s.idle == LIM && !edge_ok) |=> !running_out ##1 !running_out;
	endproperty
	a_run_clr: assert property (p_run_clr) // R4
		else $error("running flag kept after failure timeout");
endmodule : rtcot_osc_mon

// File: design/rtcot_snap.sv
// rtcot_snap: buffered copy of the timekeeping bytes, registered read.
// assumes refresh and index come from the core on the same clock.
`timescale 1ns/1ps
module rtcot_snap (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [rtcot_pkg::SNAP_WORDS-1:0][7:0] live_in,
	input wire logic refresh_in,
	input wire logic [4:0] idx_in,
	output logic [7:0] rdata_out
);
	typedef struct packed {
		logic [rtcot_pkg::SNAP_WORDS-1:0][7:0] mem;
		logic [7:0] rdata;
	} rtcot_snap_t;
	rtcot_snap_t s;
	rtcot_snap_t next_s;
	logic [rtcot_pkg::SNAP_WORDS-1:0][7:0] src;

	// ----------------------------------------
	// capture and read
	// ----------------------------------------
	always_comb begin
		next_s = s;
		// a refresh reads straight from live so the first byte is fresh
		src = refresh_in ? live_in : s.mem;
		if (refresh_in)
			next_s.mem = live_in;
		if (idx_in < 5'(rtcot_pkg::SNAP_WORDS))
			next_s.rdata = src[idx_in[2:0]];
		else
			next_s.rdata = 8'h00;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign rdata_out = s.rdata;
endmodule : rtcot_snap

// File: verif/rtcot_osc_src.sv
// rtcot_osc_src: square wave standing in for the crystal or clock source.
// assumes the bench shortens the period so that one second fits the run.
`timescale 1ns/1ps
module rtcot_osc_src #(
	parameter real HALF_NS = 25.0
) (
	input wire logic run_in,
	output logic osc_out
);
// ----------------------------------------
// waveform
// ----------------------------------------
// a stopped source holds the pin low, so no stray edge is ever counted;
// the odd start offset keeps edges away from the core clock edges
initial begin
	osc_out = 1'b0;
	#7;
	forever begin
		#(HALF_NS);
		osc_out = run_in ? ~osc_out : 1'b0;
	end
end
endmodule : rtcot_osc_src

// File: verif/rtcot_core_tb.sv
// rtcot_core_tb: self-checking bench for the timekeeping core.
// assumes rtcot_osc_src on the pin and no serial front end.
`timescale 1ns/1ps
module rtcot_core_tb;
// ----------------------------------------
// clock, design and source
// ----------------------------------------
localparam int unsigned OSF = 20;
logic ref_clk_in = 1'b0;
logic rst_n_in = 1'b0;
logic src_run = 1'b0;
logic osc_pin;
rtcot_pkg::rtcot_req_t req = '0;
logic [7:0] rdata;
logic flag;
logic [7:0] d;
int bad_count = 0;
int compares = 0;
// write addr, write data, read addr, expected byte
localparam logic [31:0] ROWS [13] = '{
	32'h00590059, 32'h01300130, 32'h02650265, 32'h02230223,
	32'h03ff0307, 32'h04310431, 32'h05320512, 32'h06240532,
	32'h06000512, 32'h06990699, 32'h07f707f7, 32'h08aa0800,
	32'h1f551f00};
localparam logic [7:0] DEFS [8] = '{8'h00, 8'h00, 8'h00, 8'h01,
	8'h01, 8'h01, 8'h01, 8'h00};
localparam logic [7:0] ROLL [7] = '{8'h80, 8'h00, 8'h00, 8'h21,
	8'h01, 8'h01, 8'h00};
always #12.5 ref_clk_in = ~ref_clk_in;
rtcot_core #(.OSF_CYCLES(OSF)) dut_u (
	.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in),
	.osc_input_pin_in(osc_pin),
	.req_in(req),
	.rdata_out(rdata),
	.osc_running_flag_out(flag));
rtcot_osc_src #(.HALF_NS(25.0)) src_u (.run_in(src_run), .osc_out(osc_pin));
// ----------------------------------------
// tasks
// ----------------------------------------
task automatic check(input logic [7:0] seen, input logic [7:0] want);
	compares++;
	if (seen !== want) begin
		bad_count++;
		$display("BAD t=%0t seen %h want %h", $time, seen, want);
	end
endtask : check
task automatic tick(input int n);
	repeat (n) @(posedge ref_clk_in);
	#2;
endtask : tick
task automatic wr(input logic [7:0] a, input logic [7:0] v);
	tick(1);
	req.addr = a;
	req.wdata = v;
	req.wr = 1'b1;
	tick(1);
	req.wr = 1'b0;
endtask : wr
task automatic rd(input logic [7:0] a, output logic [7:0] v);
	tick(1);
	req.addr = a;
	req.rd_start = 1'b1;
	tick(1);
	req.rd_start = 1'b0;
	v = rdata;
endtask : rd
task automatic nx(output logic [7:0] v);
	tick(1);
	req.rd_next = 1'b1;
	tick(1);
	req.rd_next = 1'b0;
	v = rdata;
endtask : nx
task automatic tally_and_finish;
	$display("checks %0d mismatches %0d", compares, bad_count);
	if (bad_count == 0 && compares > 0) begin
		$display("TB: PASS");
	end else begin
		$display("TB: FAIL");
	end
	$finish;
endtask : tally_and_finish
// ----------------------------------------
// watchdog
// ----------------------------------------
// the long wait is one shortened second of about 65600 cycles
initial begin
	tick(90000);
	bad_count++;
	$display("BAD t=%0t run hung", $time);
	tally_and_finish();
end
// ----------------------------------------
// tests
// ----------------------------------------
initial begin
	tick(3);
	rst_n_in = 1'b1;
	foreach (ROWS[i]) begin
		wr(ROWS[i][31:24], ROWS[i][23:16]);
		rd(ROWS[i][15:8], d);
		check(d, ROWS[i][7:0]);
	end
	$display("test register rows done");
	// buffer holds old minutes until a refresh event
	rd(8'h00, d);
	wr(8'h01, 8'h45);
	nx(d);
	check(d, 8'h30);
	rd(8'h21, d);
	check(d, 8'h30);
	repeat (31) nx(d);
	nx(d);
	check(d, 8'h45);
	rd(8'h01, d);
	check(d, 8'h45);
	$display("test snapshot done");
	// source running but both enables clear: no flag
	src_run = 1'b1;
	tick(100);
	check({7'h00, flag}, 8'h00);
	wr(8'h07, 8'h08);
	tick(40);
	check({7'h00, flag}, 8'h00);
	tick(60);
	check({7'h00, flag}, 8'h01);
	rd(8'h03, d);
	check(d, 8'h27);
	src_run = 1'b0;
	tick(10);
	check({7'h00, flag}, 8'h01);
	tick(30);
	check({7'h00, flag}, 8'h00);
	wr(8'h07, 8'h00);
	wr(8'h00, 8'h80);
	src_run = 1'b1;
	tick(100);
	check({7'h00, flag}, 8'h01);
	wr(8'h00, 8'h00);
	tick(40);
	check({7'h00, flag}, 8'h00);
	src_run = 1'b0;
	$display("test oscillator flag done");
	// second reset mid-run restores every default
	rst_n_in = 1'b0;
	tick(3);
	rst_n_in = 1'b1;
	rd(8'h00, d);
	check(d, DEFS[0]);
	for (int i = 1; i < 8; i++) begin
		nx(d);
		check(d, DEFS[i]);
	end
	check({7'h00, flag}, 8'h00);
	$display("test reset done");
	// load the last second of the century while stopped, then start
	wr(8'h02, 8'h23);
	wr(8'h01, 8'h59);
	wr(8'h03, 8'h07);
	wr(8'h04, 8'h31);
	wr(8'h05, 8'h12);
	wr(8'h06, 8'h99);
	src_run = 1'b1;
	wr(8'h00, 8'hd9);
	tick(65000);
	// the wrap lands near 65600 cycles after start; leave a wide margin
	for (int i = 0; i < 1000 && d !== 8'h80; i++) begin
		rd(8'h00, d);
	end
	check(d, ROLL[0]);
	for (int i = 1; i < 7; i++) begin
		nx(d);
		check(d, ROLL[i]);
	end
	$display("test rollover done");
	tally_and_finish();
end
endmodule : rtcot_core_tb
